// ### common/motor_guard_pkg.sv
// Package with register map, field layout, reset values and timing for the motor guard block.
package motor_guard_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_ADVANCE    = 4'h0;
  localparam logic [3:0] ADDR_LIMITS     = 4'h1;
  localparam logic [3:0] ADDR_LOCK_EN    = 4'h2;
  localparam logic [3:0] ADDR_STATUS     = 4'h3;
  localparam logic [3:0] ADDR_FAULT      = 4'h4;
  localparam logic [3:0] ADDR_MOTOR      = 4'h5;
  localparam logic [3:0] ADDR_ADV_RESULT = 4'h6;
  localparam logic [3:0] ADDR_VLIMIT     = 4'h7;

  // Advance register layout.
  localparam int ADV_CODE_LSB   = 0;
  localparam int ADV_MANT_W     = 4;
  localparam int ADV_SHIFT_LSB  = 4;
  localparam int ADV_SHIFT_W    = 3;
  localparam int ADV_SELECT_BIT = 7;

  // Limits register layout.
  localparam int ACCEL_THR_LSB = 0;
  localparam int ACCEL_THR_W   = 4;
  localparam int LOCK_THR_LSB  = 4;
  localparam int LOCK_THR_W    = 3;

  // Motor register layout: phase resistance and BEMF constant.
  localparam int RM_LSB = 0;
  localparam int KT_LSB = 8;
  localparam int COEF_W = 7;

  // Status register layout.
  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_HIZ_BIT    = 1;
  localparam int ST_SURGE_BIT  = 2;
  localparam int ST_OC_BIT     = 3;
  localparam int ST_ACCEL_BIT  = 4;

  localparam int LOCK_SCHEMES = 6;

  // Reset values.
  localparam logic [7:0] ADVANCE_RST  = 8'h00;
  localparam logic [6:0] LIMITS_RST   = 7'h7f;
  localparam logic [5:0] LOCK_EN_RST  = 6'h3f;
  localparam logic [6:0] RM_RST       = 7'h10;
  localparam logic [6:0] KT_RST       = 7'h10;

  // Advance step is 2.5 us, held as tenths of a microsecond.
  localparam int ADV_STEP_TENTHS_US = 25;
  localparam real ADV_MAX_US = 4800.0;

  // Clock and retry timing.
  localparam int CLK_HZ       = 10_000_000;
  localparam int LOCK_OFF_MS  = 5000;
  localparam int LOCK_OFF_CYC = LOCK_OFF_MS * (CLK_HZ / 1000);
  localparam int SURGE_US     = 100;
  localparam int SURGE_CYC    = SURGE_US * (CLK_HZ / 1_000_000);

  // Analogue measurements supplied by the motor front end.
  typedef struct packed {
    logic [9:0] phase_amp;
    logic [9:0] bemf_amp;
    logic [9:0] speed;
    logic [7:0] low_side_current;
    logic       closed_loop;
    logic       overcurrent;
  } sense_type;

  typedef struct packed {
    logic       hiz;
    logic       surge_active;
    logic [9:0] volt_limit;
    logic       accel_limiting;
  } drive_type;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SURGE = 2'b01,
    ST_OFF   = 2'b10,
    ST_OC    = 2'b11
  } sup_state_type;

endpackage

// ### src/advance_calc.sv
// Commutation advance time calculation from the seven-bit advance code.
`timescale 1ns/10ps
module advance_calc (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Configuration
  input  wire logic [6:0]  i_code,
  input  wire logic        i_scale_select,
  // Amplitudes
  input  wire logic [9:0]  i_phase_amp,
  input  wire logic [9:0]  i_bemf_amp,
  // Result in tenths of a microsecond
  output logic      [15:0] o_advance
);

  logic [3:0]  mant;
  logic [2:0]  shft;
  logic [15:0] setting;
  logic [25:0] scaled;
  logic [9:0]  diff;

  assign mant = i_code[motor_guard_pkg::ADV_MANT_W-1:0];
  assign shft = i_code[motor_guard_pkg::ADV_SHIFT_LSB +: motor_guard_pkg::ADV_SHIFT_W];

  // Code 0x7f gives 25*15<<7 = 48000 tenths, the 4800 us ceiling.
  always_comb begin
    setting = 16'((16'(mant) * 16'(motor_guard_pkg::ADV_STEP_TENTHS_US)) << shft);
    diff    = (i_phase_amp > i_bemf_amp) ? (i_phase_amp - i_bemf_amp) : 10'h000;
    scaled  = 26'(setting) * 26'(diff);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_advance <= 16'h0000;
    end else if (!i_scale_select) begin
      o_advance <= setting;
    end else if (i_phase_amp == 10'h000) begin
      o_advance <= 16'h0000;
    end else begin
      o_advance <= 16'(scaled / 26'(i_phase_amp));
    end
  end

endmodule

// ### src/motor_guard.sv
// Current limit, lock supervision and advance timing control for a sensorless motor driver.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module motor_guard #(
  parameter int LOCK_OFF_CYCLES = motor_guard_pkg::LOCK_OFF_CYC,
  parameter int SURGE_CYCLES    = motor_guard_pkg::SURGE_CYC
) (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  // Register port
  input  wire logic [3:0]                i_addr,
  input  wire logic [15:0]               i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [15:0]               o_rdata,
  // Front end measurements and lock detector events
  input  wire motor_guard_pkg::sense_type i_sense,
  input  wire logic [5:0]                i_lock_events,
  // Drive control
  output motor_guard_pkg::drive_type     o_drive,
  output logic      [15:0]               o_advance
);

  logic [7:0]  advance_reg;
  logic [6:0]  limits_reg;
  logic [5:0]  lock_en_reg;
  logic [6:0]  rm_reg;
  logic [6:0]  kt_reg;
  logic [5:0]  fault_cause_register;
  logic        motor_locked_flag;
  logic        restart_pulse;
  logic [31:0] count_reg;
  logic [15:0] advance_val;
  logic [5:0]  lock_events_sync1;
  logic [5:0]  lock_events_sync2;
  logic        oc_sync1;
  logic        oc_sync2;
  logic [5:0]  lock_hits;
  logic        lock_trip;
  logic        overcurrent_guard;
  logic [18:0] volt_cap;
  logic [9:0]  volt_cap_sat;
  logic        accel_limiting;
  logic        cur_trip;
  logic [15:0] status_word;
  motor_guard_pkg::sup_state_type state_reg;

  // Register writes.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      advance_reg <= motor_guard_pkg::ADVANCE_RST;
      limits_reg  <= motor_guard_pkg::LIMITS_RST;
      lock_en_reg <= motor_guard_pkg::LOCK_EN_RST;
      rm_reg      <= motor_guard_pkg::RM_RST;
      kt_reg      <= motor_guard_pkg::KT_RST;
    end else if (i_wr) begin
      unique case (i_addr)
        motor_guard_pkg::ADDR_ADVANCE: advance_reg <= i_wdata[7:0];
        motor_guard_pkg::ADDR_LIMITS:  limits_reg  <= i_wdata[6:0];
        motor_guard_pkg::ADDR_LOCK_EN: lock_en_reg <= i_wdata[5:0];
        motor_guard_pkg::ADDR_MOTOR: begin
          rm_reg <= i_wdata[motor_guard_pkg::RM_LSB +: motor_guard_pkg::COEF_W];
          kt_reg <= i_wdata[motor_guard_pkg::KT_LSB +: motor_guard_pkg::COEF_W];
        end
        default: ;
      endcase
    end
  end

  // Register reads; unmapped addresses return zero.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        motor_guard_pkg::ADDR_ADVANCE:    o_rdata <= {8'h00, advance_reg};
        motor_guard_pkg::ADDR_LIMITS:     o_rdata <= {9'h000, limits_reg};
        motor_guard_pkg::ADDR_LOCK_EN:    o_rdata <= {10'h000, lock_en_reg};
        motor_guard_pkg::ADDR_STATUS:     o_rdata <= status_word;
        motor_guard_pkg::ADDR_FAULT:      o_rdata <= {10'h000, fault_cause_register};
        motor_guard_pkg::ADDR_MOTOR:      o_rdata <= {1'b0, kt_reg, 1'b0, rm_reg};
        motor_guard_pkg::ADDR_ADV_RESULT: o_rdata <= advance_val;
        motor_guard_pkg::ADDR_VLIMIT:     o_rdata <= {6'h00, o_drive.volt_limit};
        default:                          o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // Lock events and overcurrent come from analogue comparators, so synchronise them.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lock_events_sync1 <= 6'h00;
      lock_events_sync2 <= 6'h00;
      oc_sync1          <= 1'b0;
      oc_sync2          <= 1'b0;
    end else begin
      lock_events_sync1 <= i_lock_events;
      lock_events_sync2 <= lock_events_sync1;
      oc_sync1          <= i_sense.overcurrent;
      oc_sync2          <= oc_sync1;
    end
  end

  // Status word assembled at its named bit positions.
  always_comb begin
    status_word                                   = 16'h0000;
    status_word[motor_guard_pkg::ST_LOCKED_BIT]  = motor_locked_flag;
    status_word[motor_guard_pkg::ST_HIZ_BIT]     = o_drive.hiz;
    status_word[motor_guard_pkg::ST_SURGE_BIT]   = o_drive.surge_active;
    status_word[motor_guard_pkg::ST_OC_BIT]      = (state_reg == motor_guard_pkg::ST_OC);
    status_word[motor_guard_pkg::ST_ACCEL_BIT]   = accel_limiting;
  end

  // Low-side current compare: threshold field scaled into the current code range.
  assign cur_trip = i_sense.low_side_current >
                    {limits_reg[motor_guard_pkg::LOCK_THR_LSB +: motor_guard_pkg::LOCK_THR_W],
                     5'h1f};

  // Raw hits feed the cause register whether enabled or not.
  always_comb begin
    lock_hits    = lock_events_sync2;
    lock_hits[0] = lock_events_sync2[0] | cur_trip;
  end

  assign lock_trip = (state_reg == motor_guard_pkg::ST_RUN) &&
                     |(lock_hits & lock_en_reg);
  assign overcurrent_guard = oc_sync2;
  assign restart_pulse = (state_reg == motor_guard_pkg::ST_OFF) &&
                         (count_reg == 32'(LOCK_OFF_CYCLES - 1));

  // Fault cause: set wins over the clear at restart.
  genvar g;
  generate
    for (g = 0; g < motor_guard_pkg::LOCK_SCHEMES; g = g + 1) begin : g_cause
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          fault_cause_register[g] <= 1'b0;
        end else if (lock_hits[g]) begin
          fault_cause_register[g] <= 1'b1;
        end else if (restart_pulse) begin
          fault_cause_register[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Supervisor: run, anti-surge, lock-off wait, overcurrent hold.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg         <= motor_guard_pkg::ST_RUN;
      count_reg         <= 32'h0000_0000;
      motor_locked_flag <= 1'b0;
    end else begin
      unique case (state_reg)
        motor_guard_pkg::ST_RUN: begin
          count_reg <= 32'h0000_0000;
          if (lock_trip) begin
            state_reg         <= motor_guard_pkg::ST_SURGE;
            motor_locked_flag <= 1'b1;
          end else if (overcurrent_guard) begin
            state_reg <= motor_guard_pkg::ST_OC;
          end
        end
        motor_guard_pkg::ST_SURGE: begin
          if (count_reg == 32'(SURGE_CYCLES - 1)) begin
            state_reg <= motor_guard_pkg::ST_OFF;
            count_reg <= 32'h0000_0000;
          end else begin
            count_reg <= count_reg + 32'h0000_0001;
          end
        end
        motor_guard_pkg::ST_OFF: begin
          if (restart_pulse) begin
            state_reg         <= motor_guard_pkg::ST_RUN;
            motor_locked_flag <= 1'b0;
            count_reg         <= 32'h0000_0000;
          end else begin
            count_reg <= count_reg + 32'h0000_0001;
          end
        end
        motor_guard_pkg::ST_OC: begin
          // The surge handling runs to its end even if the overcurrent clears early.
          if (count_reg != 32'(SURGE_CYCLES)) begin
            count_reg <= count_reg + 32'h0000_0001;
          end else if (!overcurrent_guard) begin
            state_reg <= motor_guard_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  // Acceleration limit: voltage cap from programmed coefficients, no current sense.
  always_comb begin
    // Operands are widened before the products so that neither term wraps.
    volt_cap = 19'(limits_reg[motor_guard_pkg::ACCEL_THR_LSB +: motor_guard_pkg::ACCEL_THR_W])
               * 19'(rm_reg) + ((19'(i_sense.speed) * 19'(kt_reg)) >> 4);
    volt_cap_sat   = (volt_cap > 19'h003ff) ? 10'h3ff : volt_cap[9:0];
    accel_limiting = i_sense.closed_loop && (i_sense.phase_amp > volt_cap_sat);
  end

  // Drive outputs; surge procedure also precedes the overcurrent high impedance.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_drive <= '0;
    end else begin
      o_drive.hiz            <= (state_reg != motor_guard_pkg::ST_RUN);
      o_drive.surge_active   <= (state_reg == motor_guard_pkg::ST_SURGE) ||
                                ((state_reg == motor_guard_pkg::ST_OC) &&
                                 (count_reg < 32'(SURGE_CYCLES)));
      o_drive.volt_limit     <= i_sense.closed_loop ? volt_cap_sat : 10'h3ff;
      o_drive.accel_limiting <= accel_limiting;
    end
  end

  advance_calc u_adv (
    .i_clk          (i_clk),
    .i_resetn       (i_resetn),
    .i_code         (advance_reg[6:0]),
    .i_scale_select (advance_reg[motor_guard_pkg::ADV_SELECT_BIT]),
    .i_phase_amp    (i_sense.phase_amp),
    .i_bemf_amp     (i_sense.bemf_amp),
    .o_advance      (advance_val)
  );

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_advance <= 16'h0000;
    end else begin
      o_advance <= advance_val;
    end
  end

endmodule

// ### verif/motor_guard_asserts.sv
// Port checker for the motor guard block, bound onto every instance.
`timescale 1ns/10ps
module motor_guard_asserts #(
  parameter int LOCK_OFF_CYCLES = 20,
  parameter int SURGE_CYCLES    = 4
) (
  input wire logic                       i_clk,
  input wire logic                       i_resetn,
  input wire logic [3:0]                 i_addr,
  input wire logic [15:0]                i_wdata,
  input wire logic                       i_wr,
  input wire logic                       i_rd,
  input wire logic [15:0]                o_rdata,
  input wire motor_guard_pkg::sense_type i_sense,
  input wire logic [5:0]                 i_lock_events,
  input wire motor_guard_pkg::drive_type o_drive,
  input wire logic [15:0]                o_advance
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic [15:0] surge_cnt_reg;
  logic [15:0] off_cnt_reg;
  logic        after_surge_reg;
  logic        oc_seen_reg;
  // The off counter only means something after a lock; an overcurrent hold has no fixed length.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      surge_cnt_reg   <= 16'h0;
      off_cnt_reg     <= 16'h0;
      after_surge_reg <= 1'b0;
      oc_seen_reg     <= 1'b0;
    end else begin
      surge_cnt_reg   <= o_drive.surge_active ? surge_cnt_reg + 16'h1 : 16'h0;
      off_cnt_reg     <= (o_drive.hiz && !o_drive.surge_active) ? off_cnt_reg + 16'h1 : 16'h0;
      after_surge_reg <= o_drive.surge_active || (o_drive.hiz && after_surge_reg);
      oc_seen_reg     <= i_sense.overcurrent || (o_drive.hiz && oc_seen_reg);
    end
  end
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
    else $error("read data not zero outside the read slot");
  open_cap_a: assert property (!i_sense.closed_loop [*6] |-> o_drive.volt_limit == 10'h3ff)
    else $error("voltage cap active in open loop");
  oc_hold_a: assert property (i_sense.overcurrent [*6] |-> o_drive.hiz)
    else $error("overcurrent did not stop the drive");
  surge_hiz_a: assert property (o_drive.surge_active |-> ##[0:1] o_drive.hiz)
    else $error("surge handling without floating outputs");
  surge_len_a: assert property ($fell(o_drive.surge_active) |-> surge_cnt_reg == 16'(SURGE_CYCLES))
    else $error("surge handling length wrong");
  surge_first_a: assert property ($rose(o_drive.hiz) |-> o_drive.surge_active)
    else $error("outputs floated without surge handling");
  off_hold_a: assert property ($fell(o_drive.surge_active) && !oc_seen_reg |-> o_drive.hiz [*8])
    else $error("drive resumed too early after surge");
  restart_time_a: assert property ($fell(o_drive.hiz) && after_surge_reg && !oc_seen_reg |->
    off_cnt_reg >= 16'(LOCK_OFF_CYCLES - 2) && off_cnt_reg <= 16'(LOCK_OFF_CYCLES + 2))
    else $error("restart after lock off interval mistimed");
  adv_fixed_a: assert property (i_wr && i_addr == motor_guard_pkg::ADDR_ADVANCE && !i_wdata[7]
    ##1 !i_wr [*3] |-> o_advance == (16'($past(i_wdata[3:0], 3)) * 16'h19) << $past(i_wdata[6:4], 3))
    else $error("fixed advance time wrong");
endmodule
bind motor_guard motor_guard_asserts #(
  .LOCK_OFF_CYCLES(LOCK_OFF_CYCLES),
  .SURGE_CYCLES   (SURGE_CYCLES)
) motor_guard_asserts_inst (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sense(i_sense),
  .i_lock_events(i_lock_events), .o_drive(o_drive), .o_advance(o_advance)
);

// ### verif/motor_model.sv
// Motor winding and sense front end model.
`timescale 1ns/10ps
module motor_model (
  // Drive from the block
  input  wire motor_guard_pkg::drive_type i_drive,
  // Bench commands
  input  wire motor_guard_pkg::sense_type i_cmd,
  // Sense to the block
  output motor_guard_pkg::sense_type      o_sense
);
  // Floating phases carry no low-side current, so a current trip cannot hold itself on.
  always_comb begin
    o_sense = i_cmd;
    if (i_drive.hiz) begin
      o_sense.low_side_current = 8'h00;
    end
  end
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the motor guard block.
`timescale 1ns/10ps
module tb_top;
  logic                       i_clk = 1'b0;
  logic                       i_resetn = 1'b0;
  logic [3:0]                 i_addr = 4'h0;
  logic [15:0]                i_wdata = 16'h0;
  logic                       i_wr = 1'b0;
  logic                       i_rd = 1'b0;
  logic [5:0]                 i_lock_events = 6'h0;
  logic [15:0]                o_rdata;
  logic [15:0]                o_advance;
  logic [15:0]                rd_v;
  motor_guard_pkg::sense_type cmd = '0;
  motor_guard_pkg::sense_type sense;
  motor_guard_pkg::drive_type o_drive;
  int                         n_mismatch = 0;
  int                         n_compared = 0;
  logic [6:0]  adv_code [7] = '{7'h00, 7'h01, 7'h0f, 7'h10, 7'h28, 7'h5a, 7'h7f};
  logic [15:0] adv_exp  [7] = '{16'h0, 16'h19, 16'h177, 16'h0, 16'h320, 16'h1f40, 16'hbb80};

  always #50 i_clk = ~i_clk;

  motor_guard #(.LOCK_OFF_CYCLES(20), .SURGE_CYCLES(4)) motor_guard_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sense(sense),
    .i_lock_events(i_lock_events), .o_drive(o_drive), .o_advance(o_advance)
  );
  motor_model motor_model_inst (.i_drive(o_drive), .i_cmd(cmd), .o_sense(sense));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_v = o_rdata;
  endtask
  task automatic wait_hiz(input logic v);
    int i;
    for (i = 0; i < 100 && o_drive.hiz !== v; i++) @(posedge i_clk);
    chk({15'h0, o_drive.hiz}, {15'h0, v});
  endtask
  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(motor_guard_pkg::ADDR_LIMITS);
    chk(rd_v, 16'h007f);
    rd(motor_guard_pkg::ADDR_LOCK_EN);
    chk(rd_v, 16'h003f);
    rd(motor_guard_pkg::ADDR_MOTOR);
    chk(rd_v, 16'h1010);
    rd(4'hf);
    chk(rd_v, 16'h0000);
    for (int r = 0; r < 7; r++) begin
      wr(motor_guard_pkg::ADDR_ADVANCE, {9'h0, adv_code[r]});
      repeat (4) @(posedge i_clk);
      chk(o_advance, adv_exp[r]);
      rd(motor_guard_pkg::ADDR_ADV_RESULT);
      chk(rd_v, adv_exp[r]);
    end
    cmd.phase_amp <= 10'h064;
    cmd.bemf_amp <= 10'h032;
    wr(motor_guard_pkg::ADDR_ADVANCE, 16'h00ff);
    repeat (6) @(posedge i_clk);
    chk(o_advance, 16'h5dc0);
    cmd.phase_amp <= 10'h000;
    repeat (6) @(posedge i_clk);
    chk(o_advance, 16'h0000);
    // Cap is 3 * 10 plus 32 * 16 / 16, so both terms matter.
    cmd.closed_loop <= 1'b1;
    cmd.speed <= 10'h020;
    cmd.phase_amp <= 10'h064;
    wr(motor_guard_pkg::ADDR_LIMITS, 16'h0073);
    wr(motor_guard_pkg::ADDR_MOTOR, 16'h100a);
    repeat (6) @(posedge i_clk);
    chk({6'h0, o_drive.volt_limit}, 16'h003e);
    chk({15'h0, o_drive.accel_limiting}, 16'h0001);
    rd(motor_guard_pkg::ADDR_VLIMIT);
    chk(rd_v, 16'h003e);
    rd(motor_guard_pkg::ADDR_STATUS);
    chk(rd_v, 16'h0010);
    chk({15'h0, o_drive.hiz}, 16'h0000);
    wr(motor_guard_pkg::ADDR_LIMITS, 16'h007f);
    wr(motor_guard_pkg::ADDR_MOTOR, 16'h7f7f);
    repeat (6) @(posedge i_clk);
    chk({6'h0, o_drive.volt_limit}, 16'h03ff);
    chk({15'h0, o_drive.accel_limiting}, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      i_lock_events <= 6'h01 << k;
      repeat (3) @(posedge i_clk);
      i_lock_events <= 6'h00;
      wait_hiz(1'b1);
      rd(motor_guard_pkg::ADDR_STATUS);
      chk(rd_v & 16'h0003, 16'h0003);
      rd(motor_guard_pkg::ADDR_FAULT);
      chk(rd_v, 16'h0001 << k);
      wait_hiz(1'b0);
      rd(motor_guard_pkg::ADDR_FAULT);
      chk(rd_v, 16'h0000);
    end
    wr(motor_guard_pkg::ADDR_LOCK_EN, 16'h003b);
    i_lock_events <= 6'h04;
    repeat (8) @(posedge i_clk);
    i_lock_events <= 6'h00;
    chk({15'h0, o_drive.hiz}, 16'h0000);
    rd(motor_guard_pkg::ADDR_FAULT);
    chk(rd_v, 16'h0004);
    wr(motor_guard_pkg::ADDR_LOCK_EN, 16'h003f);
    wr(motor_guard_pkg::ADDR_LIMITS, 16'h0030);
    cmd.low_side_current <= 8'h7f;
    repeat (8) @(posedge i_clk);
    chk({15'h0, o_drive.hiz}, 16'h0000);
    cmd.low_side_current <= 8'h80;
    wait_hiz(1'b1);
    rd(motor_guard_pkg::ADDR_FAULT);
    chk(rd_v & 16'h0001, 16'h0001);
    cmd.low_side_current <= 8'h00;
    wait_hiz(1'b0);
    cmd.overcurrent <= 1'b1;
    wait_hiz(1'b1);
    repeat (30) @(posedge i_clk);
    rd(motor_guard_pkg::ADDR_STATUS);
    chk(rd_v & 16'h000f, 16'h000a);
    cmd.overcurrent <= 1'b0;
    wait_hiz(1'b0);
    i_lock_events <= 6'h02;
    repeat (6) @(posedge i_clk);
    i_lock_events <= 6'h00;
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk({15'h0, o_drive.hiz}, 16'h0000);
    i_resetn <= 1'b1;
    rd(motor_guard_pkg::ADDR_FAULT);
    chk(rd_v, 16'h0000);
    finish_test();
  end
endmodule
